// ---- tag_mem_pkg.sv ----
// package of constants and carrier types for the tag block memory
package tag_mem_pkg;
	localparam int          BLOCK_COUNT     = 16;           // main memory blocks
	localparam int          WORD_W          = 32;           // bits per block
	localparam int          ADDR_W          = 8;            // block address width
	localparam int          ID_W            = 8;            // select identifier width
	localparam logic [7:0]  LAST_USER_A     = 8'h04;        // end of first user area
	localparam logic [7:0]  COUNTER_A_ADDR  = 8'h05;        // down_counter_a
	localparam logic [7:0]  COUNTER_B_ADDR  = 8'h06;        // down_counter_b
	localparam logic [7:0]  FIRST_USER_B    = 8'h07;        // start of second user area
	localparam logic [7:0]  LAST_USER_B     = 8'h0F;        // end of second user area
	localparam logic [7:0]  SYSTEM_ADDR     = 8'hFF;        // system_lock_and_id_block
	localparam int          LOCK_LSB        = 16;           // lock bit of block 0
	localparam int          ID_LSB          = 0;            // fixed identifier field
	localparam logic [31:0] COUNTER_RESET   = 32'hFFFFFFFF; // counter initial value
	localparam logic [31:0] USER_RESET      = 32'hFFFFFFFF; // erased user word
	localparam logic [31:0] SYSTEM_RESET    = 32'hFFFFFFFF; // unprogrammed system word
	localparam logic [31:0] ZERO_WORD       = 32'h00000000; // exhausted or empty value
	localparam int          PROG_TIME_NS    = 5000000;      // programming time
	localparam int          CLK_PERIOD_NS   = 25;           // clock period
	localparam int          PROG_CYCLES     = PROG_TIME_NS / CLK_PERIOD_NS;

	// decoded block command from the frame logic
	typedef struct packed {
		logic              rd;   // block read pulse
		logic              wr;   // block write pulse
		logic [ADDR_W-1:0] addr; // block address
		logic [WORD_W-1:0] data; // write data
	} blk_cmd_t;

	// answer to a block read
	typedef struct packed {
		logic              valid; // one-cycle answer strobe
		logic              hit;   // address mapped
		logic [WORD_W-1:0] data;  // read data
	} blk_rsp_t;
endpackage

// ---- tag_block_memory_write_control.sv ----
// block memory with lock, counter, erase and one-time system rules
// What this block does
// RL1: sixteen 32-bit blocks, all readable
// RL2: a main block write replaces all 32 bits
// RL3: blocks 0 to 4 lockable user words
// RL4: protection can never be removed
// RL5: counters accept only strictly lower values
// RL6: counters start all ones, zero is final
// RL7: power loss keeps old counter value
// RL8: locked counter rejects every change
// RL9: blocks 7 to 15 erase then program
// RL10: system block writes only clear bits
// RL11: all-zero system block accepts nothing
// RL12: bits 16 to 31 lock blocks 0-15
// RL13: cleared lock bits never return to one
// RL14: lock changes apply after valid select
// RL15: optional fixed identifier in bits 7:0
// RL16: fixed identifier disables random identifier
// RL17: reader selects before block commands; the block answers block commands without a select
// RL18: refused writes change nothing, no error; the block still pulses wr_refused_o
module tag_block_memory_write_control
	import tag_mem_pkg::*;
#(
	parameter int        PROG_CYC     = PROG_CYCLES, // programming cycle count
	parameter bit        FIXED_ID_OPT = 1'b0,        // fixed identifier mask option
	parameter logic [7:0] FIXED_ID    = 8'h5A        // fixed identifier, arbitrary value
)
(
	// clock and reset
	input  wire logic            clk_i,
	input  wire logic            arst_n_i,
	// decoded commands from frame logic
	input  wire blk_cmd_t        cmd_i,
	input  wire logic            select_ok_i,
	input  wire logic [ID_W-1:0] random_id_i,
	input  wire logic            power_fail_i,
	// answers
	output blk_rsp_t             rsp_o,
	output logic                 busy_o,
	output logic                 wr_done_o,
	output logic                 wr_refused_o,
	output logic [ID_W-1:0]      tag_select_id_o,
	output logic                 fixed_id_en_o
);
	// programming sequencer states
	typedef enum {PS_IDLE, PS_ERASE, PS_PROG} prog_state_t;

	logic                    rst_s1_r;                 // reset release stage one
	logic                    rst_n_r;                  // released reset
	logic [WORD_W-1:0]       mem_r [BLOCK_COUNT];      // main blocks
	logic [WORD_W-1:0]       sys_r;                    // system block
	logic [BLOCK_COUNT-1:0]  lock_act_r;               // active protection, low = locked
	prog_state_t             state_r;                  // programming sequencer
	logic [31:0]             cnt_r;                    // programming timer
	logic [ADDR_W-1:0]       wa_r;                     // pending address
	logic [WORD_W-1:0]       wd_r;                     // pending data
	logic                    accept;                   // write allowed
	logic                    prog_end;                 // programming timer done

	// main block address test
	function automatic logic is_main(input logic [ADDR_W-1:0] a);
		return a <= LAST_USER_B;
	endfunction

	// reset release through two flops
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			rst_s1_r <= 1'b0;
			rst_n_r  <= 1'b0;
		end
		else
		begin
			rst_s1_r <= 1'b1;
			rst_n_r  <= rst_s1_r;
		end
	end

	// write acceptance decision
	always_comb
	begin
		accept = 1'b0;
		if (cmd_i.wr && state_r == PS_IDLE)
		begin
			if (is_main(cmd_i.addr))
			begin
				// protected block refused, flagged on wr_refused_o
				accept = lock_act_r[cmd_i.addr[3:0]]; // RL3 RL4 RL8 RL18
				// counter only moves down
				if (cmd_i.addr == COUNTER_A_ADDR || cmd_i.addr == COUNTER_B_ADDR)
					accept = accept && (cmd_i.data < mem_r[cmd_i.addr[3:0]]); // RL5 RL6 RL18
			end
			else if (cmd_i.addr == SYSTEM_ADDR)
				accept = (sys_r != ZERO_WORD); // RL11
		end
	end

	assign prog_end = (cnt_r == 32'(PROG_CYC - 1));

	// programming sequencer with timer
	always_ff @(posedge clk_i or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			state_r <= PS_IDLE;
			cnt_r   <= 32'h00000000;
			wa_r    <= 8'h00;
			wd_r    <= 32'h00000000;
		end
		else
		begin
			case (state_r)
				PS_IDLE:
				begin
					cnt_r <= 32'h00000000;
					if (accept)
					begin
						wa_r    <= cmd_i.addr;
						wd_r    <= cmd_i.data;
						// system block skips erase
						state_r <= (cmd_i.addr == SYSTEM_ADDR) ? PS_PROG : PS_ERASE; // RL9 RL10
					end
				end
				PS_ERASE:
				begin
					// power loss aborts before commit
					if (power_fail_i)
						state_r <= PS_IDLE; // RL7
					else
						state_r <= PS_PROG;
				end
				PS_PROG:
				begin
					cnt_r <= cnt_r + 32'h00000001;
					if (power_fail_i)
						state_r <= PS_IDLE; // RL7
					else if (prog_end)
						state_r <= PS_IDLE;
				end
				default:
					state_r <= PS_IDLE;
			endcase
		end
	end

	// memory array commit at end of programming
	always_ff @(posedge clk_i or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			for (int i = 0; i < BLOCK_COUNT; i++)
				mem_r[i] <= (i == 5 || i == 6) ? COUNTER_RESET : USER_RESET; // RL6
		end
		else if (state_r == PS_PROG && prog_end && !power_fail_i && wa_r != SYSTEM_ADDR)
			mem_r[wa_r[3:0]] <= wd_r; // RL2 RL9 RL7
	end

	// system block only clears bits
	always_ff @(posedge clk_i or negedge rst_n_r)
	begin
		if (!rst_n_r)
			sys_r <= SYSTEM_RESET;
		else if (state_r == PS_PROG && prog_end && !power_fail_i && wa_r == SYSTEM_ADDR)
			sys_r <= sys_r & wd_r; // RL10 RL13 RL4
	end

	// lock bits load into protection on valid select
	always_ff @(posedge clk_i or negedge rst_n_r)
	begin
		if (!rst_n_r)
			lock_act_r <= {BLOCK_COUNT{1'b1}};
		else if (select_ok_i)
			lock_act_r <= lock_act_r & sys_r[LOCK_LSB +: BLOCK_COUNT]; // RL14 RL12 RL13
	end

	// read answer, one cycle after request
	always_ff @(posedge clk_i or negedge rst_n_r)
	begin
		if (!rst_n_r)
			rsp_o <= '0;
		else
		begin
			rsp_o.valid <= cmd_i.rd; // RL1 RL17
			rsp_o.hit   <= is_main(cmd_i.addr) || cmd_i.addr == SYSTEM_ADDR;
			if (is_main(cmd_i.addr))
				rsp_o.data <= mem_r[cmd_i.addr[3:0]]; // RL1
			else if (cmd_i.addr == SYSTEM_ADDR)
				rsp_o.data <= FIXED_ID_OPT ? {sys_r[31:8], FIXED_ID} : sys_r; // RL15
			else
				rsp_o.data <= ZERO_WORD;
		end
	end

	// status and identifier outputs
	always_ff @(posedge clk_i or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			busy_o          <= 1'b0;
			wr_done_o       <= 1'b0;
			wr_refused_o    <= 1'b0;
			tag_select_id_o <= 8'h00;
			fixed_id_en_o   <= 1'b0;
		end
		else
		begin
			busy_o          <= (state_r != PS_IDLE) || accept;
			wr_done_o       <= state_r == PS_PROG && prog_end && !power_fail_i;
			wr_refused_o    <= cmd_i.wr && !accept; // RL18
			// fixed value replaces random identifier
			tag_select_id_o <= FIXED_ID_OPT ? FIXED_ID : random_id_i; // RL16 RL15
			fixed_id_en_o   <= FIXED_ID_OPT; // RL16
		end
	end

	// counter a never rises
	a_counter_down: assert property (@(posedge clk_i) disable iff (!rst_n_r) // RL5
		mem_r[5] <= $past(mem_r[5]))
		else $error("counter a increased");

	// locked block 1 never changes
	a_lock_holds: assert property (@(posedge clk_i) disable iff (!rst_n_r) // RL8
		(!lock_act_r[1] && $past(!lock_act_r[1])) |-> $stable(mem_r[1]))
		else $error("locked block changed");

	// system bits only fall
	a_sys_clear: assert property (@(posedge clk_i) disable iff (!rst_n_r) // RL10
		(sys_r & ~$past(sys_r)) == ZERO_WORD)
		else $error("system bit rose");

	// protection only tightens
	a_lock_mono: assert property (@(posedge clk_i) disable iff (!rst_n_r) // RL13
		(lock_act_r & ~$past(lock_act_r)) == 16'h0000)
		else $error("protection removed");

	// protection changes only on select
	a_lock_select: assert property (@(posedge clk_i) disable iff (!rst_n_r) // RL14
		!$past(select_ok_i) |-> $stable(lock_act_r))
		else $error("protection changed without select");

	// read answers next cycle
	a_read_answer: assert property (@(posedge clk_i) disable iff (!rst_n_r) // RL1
		cmd_i.rd |=> rsp_o.valid)
		else $error("read answer missing");

	// refusal reported for locked write
	a_refuse_flag: assert property (@(posedge clk_i) disable iff (!rst_n_r) // RL18
		(cmd_i.wr && is_main(cmd_i.addr) && !lock_act_r[cmd_i.addr[3:0]]) |=> wr_refused_o)
		else $error("locked write not refused");

	// power fail returns idle
	a_tear_abort: assert property (@(posedge clk_i) disable iff (!rst_n_r) // RL7
		(state_r != PS_IDLE && power_fail_i) |=> (state_r == PS_IDLE && !wr_done_o))
		else $error("torn write not aborted");

	// main block write taken this cycle
	sequence s_main_taken;
		accept && is_main(cmd_i.addr);
	endsequence
	// programming finishes without field loss
	sequence s_commit;
		state_r == PS_PROG && prog_end && !power_fail_i;
	endsequence

	// second counter never rises
	a_counter_b_down: assert property (@(posedge clk_i) disable iff (!rst_n_r) // RL5
		mem_r[6] <= $past(mem_r[6]))
		else $error("counter b increased");
	// locked counter a never changes
	a_lock_counter: assert property (@(posedge clk_i) disable iff (!rst_n_r) // RL8
		(!lock_act_r[5] && $past(!lock_act_r[5])) |-> $stable(mem_r[5]))
		else $error("locked counter changed");
	// counter a write not lower is refused
	a_counter_refuse: assert property (@(posedge clk_i) disable iff (!rst_n_r) // RL5
		(cmd_i.wr && state_r == PS_IDLE && cmd_i.addr == COUNTER_A_ADDR
			&& cmd_i.data >= mem_r[5]) |=> wr_refused_o)
		else $error("counter raise not refused");
	// exhausted system word takes nothing
	a_exhaust_refuse: assert property (@(posedge clk_i) disable iff (!rst_n_r) // RL11
		(cmd_i.wr && cmd_i.addr == SYSTEM_ADDR && sys_r == ZERO_WORD) |=> wr_refused_o)
		else $error("exhausted system write taken");
	// main block write starts with erase
	a_erase_first: assert property (@(posedge clk_i) disable iff (!rst_n_r) // RL9
		s_main_taken |=> (state_r == PS_ERASE))
		else $error("main write skipped erase");
	// system write programs without erase
	a_sys_no_erase: assert property (@(posedge clk_i) disable iff (!rst_n_r) // RL10
		(accept && cmd_i.addr == SYSTEM_ADDR) |=> (state_r == PS_PROG))
		else $error("system write erased");
	// finished programming reports done
	a_commit_done: assert property (@(posedge clk_i) disable iff (!rst_n_r) // RL2
		s_commit |=> (wr_done_o && state_r == PS_IDLE))
		else $error("commit not reported");
	// committed block holds the whole word
	a_commit_word: assert property (@(posedge clk_i) disable iff (!rst_n_r) // RL2
		(state_r == PS_PROG && prog_end && !power_fail_i && is_main(wa_r))
			|=> (mem_r[wa_r[3:0]] == wd_r))
		else $error("block word not committed whole");
	// fixed identifier replaces random one
	a_fixed_id: assert property (@(posedge clk_i) disable iff (!rst_n_r) // RL16
		(FIXED_ID_OPT && $past(rst_n_r)) |-> (tag_select_id_o == FIXED_ID && fixed_id_en_o))
		else $error("fixed identifier not used");
	// without option identifier follows random source
	a_random_id: assert property (@(posedge clk_i) disable iff (!rst_n_r) // RL16
		(!FIXED_ID_OPT && $past(rst_n_r)) |-> (tag_select_id_o == $past(random_id_i)))
		else $error("random identifier not followed");
endmodule

// ---- blk_reader.sv ----
// reader model that issues block commands to the tag
module blk_reader
	import tag_mem_pkg::*;
(
	// clock and answers from the tag
	input  wire logic     clk_i,
	input  wire blk_rsp_t rsp_i,
	input  wire logic     done_i,
	input  wire logic     refused_i,
	// commands to the tag
	output blk_cmd_t      cmd_o,
	output logic          select_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// idle lines at time zero
	initial
	begin
		cmd_o    = '0;
		select_o = 1'b0;
	end
	// valid select pulse, sent first and after lock changes
	task automatic sel();
		@(posedge clk_i) select_o <= 1'b1;
		@(posedge clk_i) select_o <= 1'b0;
	endtask
	// read: answer lands one cycle after the taken edge
	task automatic rd(input logic [7:0] a, output blk_rsp_t r);
		@(posedge clk_i) cmd_o <= {1'b1, 1'b0, a, 32'h0};
		@(posedge clk_i) cmd_o <= {2'b00, ~a, 32'hFFFFFFFF};
		#1 r = rsp_i;
	endtask
	// write: st 0 done, 1 refused, 2 no answer; released lines flip
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output int st);
		st = 2;
		@(posedge clk_i) cmd_o <= {1'b0, 1'b1, a, d};
		@(posedge clk_i) cmd_o <= {2'b00, ~a, ~d};
		for (int i = 0; i < 40 && st == 2; i++)
		begin
			#1;
			if (done_i)
				st = 0;
			else if (refused_i)
				st = 1;
			@(posedge clk_i);
		end
	endtask
endmodule

// ---- tag_block_memory_write_control_test.sv ----
// self-checking bench for the tag block memory
module tag_block_memory_write_control_test
	import tag_mem_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic            clk_i    = 1'b0; // 40 MHz clock
	logic            arst_n_i = 1'b0; // reset, active low
	logic            sel_ok;          // select pulse from reader
	logic [ID_W-1:0] rid      = '0;   // random id source
	logic            pf       = 1'b0; // field lost
	blk_cmd_t        cmd;             // reader command
	blk_rsp_t        rsp;             // read answer
	logic            busy, done, refused, fid_en;
	logic [ID_W-1:0] sid;             // identifier seen
	logic [31:0]     e [0:15];        // expected blocks
	logic [31:0]     es;              // expected system word
	logic [15:0]     act;             // applied locks, 1 protects
	int              error_cnt = 0;
	int              samples_checked = 0;
	localparam logic [7:0] FIXED_VAL = 8'hC3; // fixed identifier, arbitrary value
	blk_rsp_t        rsp_fx;          // read answer, fixed id tag
	logic [ID_W-1:0] sid_fx;          // identifier, fixed id tag
	logic            fid_fx;          // option flag, fixed id tag
	tag_block_memory_write_control #(.PROG_CYC(4)) i_tag_block_memory_write_control (
		.clk_i(clk_i), .arst_n_i(arst_n_i), .cmd_i(cmd), .select_ok_i(sel_ok),
		.random_id_i(rid), .power_fail_i(pf), .rsp_o(rsp), .busy_o(busy),
		.wr_done_o(done), .wr_refused_o(refused), .tag_select_id_o(sid),
		.fixed_id_en_o(fid_en));
	// second tag built with the fixed identifier option
	tag_block_memory_write_control #(.PROG_CYC(4), .FIXED_ID_OPT(1'b1), .FIXED_ID(FIXED_VAL))
		i_tag_block_memory_write_control_fx (
		.clk_i(clk_i), .arst_n_i(arst_n_i), .cmd_i(cmd), .select_ok_i(sel_ok),
		.random_id_i(rid), .power_fail_i(pf), .rsp_o(rsp_fx), .busy_o(),
		.wr_done_o(), .wr_refused_o(), .tag_select_id_o(sid_fx),
		.fixed_id_en_o(fid_fx));
	blk_reader i_blk_reader (.clk_i(clk_i), .rsp_i(rsp), .done_i(done),
		.refused_i(refused), .cmd_o(cmd), .select_o(sel_ok));
	// free running clock
	initial
	begin
		forever #12.5 clk_i = ~clk_i;
	end
	// compare one word, count and report
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		samples_checked++;
		if (g !== x)
		begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", n, x, g);
		end
	endtask
	// verdict and end of run
	task automatic final_report();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// whether a write is taken
	function automatic logic ok(logic [7:0] a, logic [31:0] o, logic [31:0] d, logic lk);
		if (a == SYSTEM_ADDR)
			return o != ZERO_WORD;
		if (lk)
			return 1'b0;
		if (a == COUNTER_A_ADDR || a == COUNTER_B_ADDR)
			return d < o;
		return 1'b1;
	endfunction
	// read a block, check strobe, hit and word
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, input logic h);
		blk_rsp_t r;
		i_blk_reader.rd(a, r);
		chk("valid", 32'h1, {31'h0, r.valid});
		chk("hit", {31'h0, h}, {31'h0, r.hit});
		chk("data", x, r.data);
	endtask
	// write, predict, check status and read back
	task automatic wr_chk(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] o;
		logic        acc;
		int          st;
		o   = (a == SYSTEM_ADDR) ? es : e[a[3:0]];
		acc = ok(a, o, d, (a == SYSTEM_ADDR) ? 1'b0 : act[a[3:0]]);
		i_blk_reader.wr(a, d, st);
		chk("status", {31'h0, !acc}, 32'(st));
		if (st == 2)
			final_report();
		if (a == SYSTEM_ADDR)
			es = acc ? o & d : o;
		else
			e[a[3:0]] = acc ? d : o;
		rd_chk(a, (a == SYSTEM_ADDR) ? es : e[a[3:0]], 1'b1);
	endtask
	// main sequence
	initial
	begin
		logic [31:0] v;
		int          st;
		void'($urandom(32'h2601DE93));
		for (int i = 0; i < 16; i++)
			e[i] = COUNTER_RESET;
		es  = SYSTEM_RESET;
		act = '0;
		repeat (8) @(posedge clk_i);
		arst_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		i_blk_reader.sel();
		for (int i = 0; i < 16; i++)
			rd_chk(8'(i), COUNTER_RESET, 1'b1);
		rd_chk(SYSTEM_ADDR, SYSTEM_RESET, 1'b1);
		chk("fixed field", {24'h0, FIXED_VAL}, {24'h0, rsp_fx.data[7:0]});
		rd_chk(8'h10, ZERO_WORD, 1'b0);
		// counters: equal refused, lower taken, empty stays empty
		wr_chk(COUNTER_A_ADDR, 32'hFFFFFFFF);
		wr_chk(COUNTER_A_ADDR, 32'hFFFFFFFE);
		wr_chk(COUNTER_B_ADDR, ZERO_WORD);
		wr_chk(COUNTER_B_ADDR, 32'h00000001);
		// field lost while a counter programs
		fork
			i_blk_reader.wr(COUNTER_A_ADDR, 32'h00000010, st);
			begin
				repeat (2) @(posedge clk_i);
				#1 chk("busy", 32'h1, {31'h0, busy});
				@(posedge clk_i) pf <= 1'b1;
			end
		join
		chk("torn status", 32'h2, 32'(st));
		@(posedge clk_i) pf <= 1'b0;
		repeat (4) @(posedge clk_i);
		#1 chk("busy", 32'h0, {31'h0, busy});
		rd_chk(COUNTER_A_ADDR, e[5], 1'b1);
		// lock block 1 and counter a, effective only after select
		wr_chk(SYSTEM_ADDR, 32'hFFDDFFFF);
		wr_chk(8'h01, 32'h12345678);
		i_blk_reader.sel();
		act = ~es[31:16];
		wr_chk(8'h01, 32'h0BADF00D);
		wr_chk(COUNTER_A_ADDR, ZERO_WORD);
		wr_chk(SYSTEM_ADDR, 32'hFFFFFFFF);
		// random traffic over all blocks
		for (int i = 0; i < 24; i++)
		begin
			v = $urandom;
			wr_chk(8'($urandom_range(15)), v);
		end
		// identifier follows the random source, second tag shows FIXED_VAL with its flag set
		@(posedge clk_i) rid <= 8'($urandom);
		@(posedge clk_i);
		#1 chk("select id", {24'h0, rid}, {24'h0, sid});
		chk("fixed flag", 32'h0, {31'h0, fid_en});
		chk("fixed id", {24'h0, FIXED_VAL}, {24'h0, sid_fx});
		chk("fixed flag on", 32'h1, {31'h0, fid_fx});
		// exhausted system word takes nothing more
		wr_chk(SYSTEM_ADDR, ZERO_WORD);
		wr_chk(SYSTEM_ADDR, 32'hFFFFFFFF);
		final_report();
	end
endmodule
